// file: idcw_pkg.sv
// Constants for the identification capability word generator
// Overview of operation
// [RULE1] Word 63 bits 10..8 flag the selected multiword DMA mode 2, 1, 0.
// [RULE2] Word 63 bits 2..0 flag supported multiword DMA modes, cumulative; the code copies mode register bits 2..0 unchecked.
// [RULE3] Word 64 bits 7..0 hold advanced PIO mask; bits 15..8 zero.
// [RULE4] Word 65 holds minimum multiword DMA cycle time in ns.
// [RULE5] Word 66 holds recommended multiword DMA cycle time in ns.
// [RULE6] Word 67 holds minimum PIO cycle time without flow control.
// [RULE7] Word 68 holds minimum PIO cycle time with IORDY flow control.
// [RULE8] Word 71 holds typical packet command to bus release time.
// [RULE9] Word 72 holds typical packet command to busy cleared time.
// [RULE10] Word 75 bits 4..0 hold queue depth minus one; rest zero.
// [RULE11] Word 80 bits 5..2 flag supported revisions; others zero.
// [RULE12] Word 80 reads 0000h when the major version is not reported.
// [RULE13] Word 81 carries the minor version code, any 16-bit value.
// [RULE14] Word 82 flags supported commands; bit 4 always one.
// [RULE15] Words 82 and 83 read zero only when notification is off.
// [RULE16] Word 83 bit 15 zero, bit 14 one, bit 8 set-max extension.
// [RULE17] Word 83 bits 6, 5, 4, 0 flag spin-up, standby, notify, microcode.
// [RULE18] Word 84 reads 4000h, or zero when notification is off.
// [RULE19] Word 85 flags enabled features like word 82; bit 4 always one.
// [RULE20] Word 85 reads zero only when enabled notification is off.
// [RULE21] Reserved bits and words read as zero.
// [RULE22] Timing valid flag reports that words 64 to 70 are valid.
// [RULE23] Value words put their MSB on data line 15, LSB on line 0.
// [RULE24] At most one selected mode, and only a supported one.
// [RULE25] Words derive from configuration and enable state by index.
package idcw_pkg;
    // ==========================================
    // Register offsets
    localparam logic [3:0] IDCW_R_MODE = 4'h0;
    localparam logic [3:0] IDCW_R_PIO = 4'h1;
    localparam logic [3:0] IDCW_R_DMIN = 4'h2;
    localparam logic [3:0] IDCW_R_DREC = 4'h3;
    localparam logic [3:0] IDCW_R_PMIN = 4'h4;
    localparam logic [3:0] IDCW_R_PIOR = 4'h5;
    localparam logic [3:0] IDCW_R_TREL = 4'h6;
    localparam logic [3:0] IDCW_R_TBSY = 4'h7;
    localparam logic [3:0] IDCW_R_QDEP = 4'h8;
    localparam logic [3:0] IDCW_R_MAJ = 4'h9;
    localparam logic [3:0] IDCW_R_MIN = 4'hA;
    localparam logic [3:0] IDCW_R_SUP = 4'hB;
    localparam logic [3:0] IDCW_R_SUP2 = 4'hC;
    localparam logic [3:0] IDCW_R_ENA = 4'hD;
    localparam logic [3:0] IDCW_R_STAT = 4'hE;
    localparam int IDCW_NREG = 14;
    // ==========================================
    // Mode register fields
    localparam int IDCW_F_SUPP = 0;
    localparam int IDCW_F_SEL = 3;
    localparam int IDCW_F_TVAL = 5;
    localparam int IDCW_F_NOCS = 6;
    localparam int IDCW_F_NOEN = 7;
    // ==========================================
    // Word indices
    localparam logic [7:0] IDCW_W_DMA = 8'h3F;
    localparam logic [7:0] IDCW_W_PIO = 8'h40;
    localparam logic [7:0] IDCW_W_DMIN = 8'h41;
    localparam logic [7:0] IDCW_W_DREC = 8'h42;
    localparam logic [7:0] IDCW_W_PMIN = 8'h43;
    localparam logic [7:0] IDCW_W_PIOR = 8'h44;
    localparam logic [7:0] IDCW_W_TREL = 8'h47;
    localparam logic [7:0] IDCW_W_TBSY = 8'h48;
    localparam logic [7:0] IDCW_W_QDEP = 8'h4B;
    localparam logic [7:0] IDCW_W_MAJ = 8'h50;
    localparam logic [7:0] IDCW_W_MIN = 8'h51;
    localparam logic [7:0] IDCW_W_SUP = 8'h52;
    localparam logic [7:0] IDCW_W_SUP2 = 8'h53;
    localparam logic [7:0] IDCW_W_EXT = 8'h54;
    localparam logic [7:0] IDCW_W_ENA = 8'h55;
    // ==========================================
    // Fixed patterns and masks
    localparam logic [15:0] IDCW_ZERO = 16'h0000;
    localparam logic [15:0] IDCW_EXT = 16'h4000;
    localparam logic [15:0] IDCW_M_MAJ = 16'h003C;
    localparam logic [15:0] IDCW_M_SUP = 16'h77EF;
    localparam logic [15:0] IDCW_M_SUP2 = 16'h0171;
    localparam logic [15:0] IDCW_ONE4 = 16'h0010;
    // Reset values of the configuration registers
    localparam logic [15:0] IDCW_RST [IDCW_NREG] = '{
        16'h0027, 16'h0003, 16'h0078, 16'h0078, 16'h00F0, 16'h0078, 16'h0000,
        16'h0000, 16'h0000, 16'h0030, 16'h0000, 16'h0010, 16'h0000, 16'h0010};
endpackage

// file: idcw_words.sv
// Identification capability word generator, words 63 to 85
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module idcw_words import idcw_pkg::*; (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata_q,
    // Word read port
    input wire logic [7:0] word_idx,
    input wire logic word_rd,
    output logic [15:0] word_q,
    output logic word_vld_q,
    // Timing words valid flag
    output logic tval_q
);
    // ==========================================
    // Configuration registers
    logic [15:0] cfg_q [IDCW_NREG];
    logic [7:0] idx_q;

    genvar gi;
    generate
        for (gi = 0; gi < IDCW_NREG; gi++) begin : g_cfg
            // One register per entry, written by the register port
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    cfg_q[gi] <= IDCW_RST[gi];
                end else if (ce && reg_wr && reg_addr == 4'(gi)) begin
                    cfg_q[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    // ==========================================
    // Field decode
    wire [15:0] mode = cfg_q[IDCW_R_MODE];
    wire [2:0] supp = mode[IDCW_F_SUPP +: 3];
    wire [1:0] sel = mode[IDCW_F_SEL +: 2];
    wire no_cs = mode[IDCW_F_NOCS];
    wire no_en = mode[IDCW_F_NOEN];
    // Selection code 1..3 names mode 0..2; unsupported picks drop out
    wire [2:0] sel_oh = (sel == 2'd0) ? 3'b000 : 3'(3'b001 << (sel - 2'd1));
    wire [2:0] sel_eff = sel_oh & supp; // [RULE24]
    wire [15:0] w63 = {5'h00, sel_eff, 5'h00, supp}; // [RULE1] [RULE2] [RULE21]
    wire [15:0] w64 = {8'h00, cfg_q[IDCW_R_PIO][7:0]}; // [RULE3]
    wire [15:0] w75 = {11'h000, cfg_q[IDCW_R_QDEP][4:0]}; // [RULE10]
    wire [15:0] w80 = cfg_q[IDCW_R_MAJ] & IDCW_M_MAJ; // [RULE11] [RULE12]
    wire [15:0] w82 = no_cs ? IDCW_ZERO
                    : (cfg_q[IDCW_R_SUP] & IDCW_M_SUP) | IDCW_ONE4; // [RULE14] [RULE15]
    wire [15:0] w83 = no_cs ? IDCW_ZERO
                    : (cfg_q[IDCW_R_SUP2] & IDCW_M_SUP2) | IDCW_EXT; // [RULE16] [RULE17]
    wire [15:0] w84 = no_cs ? IDCW_ZERO : IDCW_EXT; // [RULE18]
    wire [15:0] w85 = no_en ? IDCW_ZERO
                    : (cfg_q[IDCW_R_ENA] & IDCW_M_SUP) | IDCW_ONE4; // [RULE19] [RULE20]

    // Word selection by index; anything else reads zero
    function automatic logic [15:0] pick(input logic [7:0] i);
        logic [15:0] r;
        r = IDCW_ZERO; // [RULE21]
        unique case (i)
            IDCW_W_DMA: r = w63;
            IDCW_W_PIO: r = w64;
            IDCW_W_DMIN: r = cfg_q[IDCW_R_DMIN]; // [RULE4] [RULE23]
            IDCW_W_DREC: r = cfg_q[IDCW_R_DREC]; // [RULE5]
            IDCW_W_PMIN: r = cfg_q[IDCW_R_PMIN]; // [RULE6]
            IDCW_W_PIOR: r = cfg_q[IDCW_R_PIOR]; // [RULE7]
            IDCW_W_TREL: r = cfg_q[IDCW_R_TREL]; // [RULE8]
            IDCW_W_TBSY: r = cfg_q[IDCW_R_TBSY]; // [RULE9]
            IDCW_W_QDEP: r = w75;
            IDCW_W_MAJ: r = w80;
            IDCW_W_MIN: r = cfg_q[IDCW_R_MIN]; // [RULE13]
            IDCW_W_SUP: r = w82;
            IDCW_W_SUP2: r = w83;
            IDCW_W_EXT: r = w84;
            IDCW_W_ENA: r = w85;
            default: r = IDCW_ZERO;
        endcase
        return r;
    endfunction

    wire [15:0] word_d = pick(word_idx); // [RULE25]
    wire [15:0] rdata_d = (reg_addr == IDCW_R_STAT) ? w63
                        : (reg_addr < 4'(IDCW_NREG)) ? cfg_q[reg_addr] : IDCW_ZERO;

    // ==========================================
    // Output registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_q <= IDCW_ZERO;
            word_vld_q <= 1'b0;
            idx_q <= 8'h00;
            reg_rdata_q <= IDCW_ZERO;
            tval_q <= 1'b0;
        end else if (ce) begin
            word_q <= word_rd ? word_d : word_q;
            word_vld_q <= word_rd;
            idx_q <= word_rd ? word_idx : idx_q;
            reg_rdata_q <= reg_rd ? rdata_d : IDCW_ZERO;
            tval_q <= mode[IDCW_F_TVAL]; // [RULE22]
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence word_req(logic [7:0] w);
        ce && word_rd && word_idx == w;
    endsequence
    wire at63 = word_vld_q && idx_q == IDCW_W_DMA;

    sel_onehot_a: assert property (at63 |-> $onehot0(word_q[10:8])) // [RULE1]
        else $error("several selected modes");
    sel_supp_a: assert property (at63 |-> (word_q[10:8] & ~word_q[2:0]) == 3'b000) // [RULE24]
        else $error("unsupported mode selected");
    w63_resv_a: assert property (at63 |-> word_q[15:11] == 5'h00 && word_q[7:3] == 5'h00) // [RULE21]
        else $error("word 63 reserved bits set");
    w64_resv_a: assert property (word_req(IDCW_W_PIO) |=> word_q[15:8] == 8'h00) // [RULE3]
        else $error("word 64 high byte set");
    dmin_val_a: assert property (word_req(IDCW_W_DMIN) |=> word_q == $past(cfg_q[IDCW_R_DMIN])) // [RULE4]
        else $error("word 65 mismatch");
    w75_resv_a: assert property (word_req(IDCW_W_QDEP) |=> word_q[15:5] == 11'h000) // [RULE10]
        else $error("word 75 reserved bits set");
    w80_bits_a: assert property (word_req(IDCW_W_MAJ) |=> (word_q & ~IDCW_M_MAJ) == IDCW_ZERO) // [RULE11]
        else $error("word 80 reserved bits set");
    w82_one_a: assert property (word_req(IDCW_W_SUP) && !no_cs |=> word_q[4]) // [RULE14]
        else $error("word 82 bit 4 clear");
    w83_fix_a: assert property (word_req(IDCW_W_SUP2) && !no_cs |=> word_q[15:14] == 2'b01) // [RULE16]
        else $error("word 83 fixed bits wrong");
    w84_fix_a: assert property (word_req(IDCW_W_EXT) |=>
        word_q == ($past(no_cs) ? IDCW_ZERO : IDCW_EXT)) // [RULE18]
        else $error("word 84 wrong");
    w85_one_a: assert property (word_req(IDCW_W_ENA) && !no_en |=> word_q[4]) // [RULE19]
        else $error("word 85 bit 4 clear");
    // Read data only stands in the cycle after a register read
    rdata_idle_a: assert property (ce && !reg_rd |=> reg_rdata_q == IDCW_ZERO) // [RULE25]
        else $error("read data not cleared");
    // Word output holds and the valid pulse stays low without a request
    word_hold_a: assert property (ce && !word_rd |=> $stable(word_q) && !word_vld_q) // [RULE25]
        else $error("word output moved without request");
    // Timing valid flag follows its mode bit one cycle later
    tval_cp_a: assert property (ce |=> tval_q == $past(mode[IDCW_F_TVAL])) // [RULE22]
        else $error("timing valid flag wrong");
    rd_lat_a: assert property (ce && word_rd |=> word_vld_q) // [RULE25]
        else $error("word answer late");
endmodule // idcw_words

// file: idcw_host.sv
// Host adapter model that fetches identification words one at a time
`timescale 1ns/1ps
module idcw_host (
    // Clock
    input wire logic clk,
    // Word port
    output logic [7:0] word_idx,
    output logic word_rd,
    input wire logic [15:0] word_q,
    input wire logic word_vld_q
);
    // ==========================================
    // Idle state at time zero
    initial begin
        word_idx = 8'h00;
        word_rd = 1'b0;
    end
    // One word fetch; the index is scrambled once released
    task automatic rd(input logic [7:0] idx, output logic [15:0] val, output logic vld);
        word_idx <= idx;
        word_rd <= 1'b1;
        @(posedge clk);
        word_rd <= 1'b0;
        word_idx <= ~idx;
        #1;
        val = word_q;
        vld = word_vld_q;
        @(posedge clk);
    endtask
endmodule // idcw_host

// file: tb_top.sv
// Self-checking testbench for the identification capability words
`timescale 1ns/1ps
module tb_top;
    import idcw_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata_q, word_q, v, d, lfsr = 16'h0010;
    logic [7:0] word_idx;
    logic word_rd, word_vld_q, tval_q, vl;
    logic [15:0] sh [IDCW_NREG];
    int n_errors = 0, total_checks = 0, cyc = 0;
    // ==========================================
    // Clock, design and host model
    initial forever #2 clk = ~clk;
    idcw_words dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .word_idx(word_idx),
        .word_rd(word_rd), .word_q(word_q), .word_vld_q(word_vld_q), .tval_q(tval_q));
    idcw_host host (.clk(clk), .word_idx(word_idx), .word_rd(word_rd), .word_q(word_q),
        .word_vld_q(word_vld_q));
    // ==========================================
    // Helpers
    task automatic stop_test();
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input int k, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s %0d expected %h seen %h", n, k, e, g);
            n_errors++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] x);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rr(input logic [3:0] a, output logic [15:0] x);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 x = reg_rdata_q;
        @(posedge clk);
    endtask
    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // Expected word from the shadow of the configuration
    function automatic logic [15:0] exp_word(input int w);
        logic [15:0] m;
        m = sh[0];
        case (w)
            63: return {5'h00, m[4:3] == 2'd3 && m[2], m[4:3] == 2'd2 && m[1],
                m[4:3] == 2'd1 && m[0], 5'h00, m[2:0]};
            64: return {8'h00, sh[1][7:0]};
            65, 66, 67, 68: return sh[w - 63];
            71, 72: return sh[w - 65];
            75: return {11'h000, sh[8][4:0]};
            80: return sh[9] & 16'h003C;
            81: return sh[10];
            82: return m[6] ? 16'h0000 : (sh[11] & 16'h77EF) | 16'h0010;
            83: return m[6] ? 16'h0000 : (sh[12] & 16'h0171) | 16'h4000;
            84: return m[6] ? 16'h0000 : 16'h4000;
            85: return m[7] ? 16'h0000 : (sh[13] & 16'h77EF) | 16'h0010;
            default: return 16'h0000;
        endcase
    endfunction
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            stop_test();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        sh = IDCW_RST;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 16; a++) begin
            rr(a[3:0], v);
            chk("reg", a, a < 14 ? IDCW_RST[a] : (a == 14 ? exp_word(63) : 16'h0000), v);
        end
        for (int r = 0; r < 24; r++) begin
            for (int a = 0; a < 15; a++) begin
                lfsr = nxt(lfsr);
                d = r == 0 ? 16'h0000 : (r == 1 ? 16'hFFFF : lfsr);
                if (a == 0 && r > 1 && r < 10) d = {11'h000, r[1:0], r[2] ? 3'b101 : 3'b111};
                wr(a[3:0], d);
                if (a < 14) sh[a] = d;
            end
            chk("tval", r, {15'h0000, sh[0][5]}, {15'h0000, tval_q});
            for (int a = 0; a < 15; a++) begin
                rr(a[3:0], v);
                chk("readback", a, a < 14 ? sh[a] : exp_word(63), v);
            end
            for (int w = 60; w < 89; w++) begin
                host.rd(w[7:0], v, vl);
                chk("word", w, exp_word(w), v);
            end
        end
        ce <= 1'b0;
        host.rd(8'h41, v, vl);
        chk("frozen", 0, 16'h0000, {15'h0000, vl});
        chk("frozen_word", 0, 16'h0000, v);
        ce <= 1'b1;
        stop_test();
    end
endmodule // tb_top
